//--- hw/oscd_top.sv
// Oscillator-stop detection, power-up defaults and serial number block.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
// Overview of operation
// R1: Eight-byte read-only serial number; writes never change it.
// R2: Oscillator stop, including low supply, sets the fail flag.
// R3: First power-up brings the fail flag up as one.
// R4: Writing halt-oscillator to one also sets the fail flag.
// R5: Flag set and its enable high drives the active-low interrupt pin.
// R6: Flag clear, enable clear or reset output removes it; reads do not.
// R7: Fail flag is sticky until software writes zero.
// R8: Host waits four seconds of oscillation before clearing the flag.
// R9: Detection works on main power and in battery backup.
// R10: Interrupt pin drives in backup only with alarm-in-backup enable.
// R11: Initial power-up loads the listed control defaults.
// R12: Battery-backed power-up keeps some bits, clears others on edges.
// R13: Any tamper enable stops halt-update being set at power-down.
// R14: Clock output enable one, threshold and tamper bits zero initially.
// R15: Clock output only while main supply is present.
// R16: Unlisted control bits need no defined value after power-up.
module oscd_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire oscd_pkg::oscd_apb_req_type apb_req,
    output oscd_pkg::oscd_apb_rsp_type apb_rsp,
    input wire logic osc_running,
    input wire logic main_supply_ok,
    input wire logic reset_out_active,
    input wire logic alarm_irq,
    input wire logic clk32k_in,
    output logic irq_out_n_o,
    output logic irq_out_n_oe,
    output logic clk32k_out,
    output logic irq
);
    import oscd_pkg::*;

    logic osc_s1_reg;
    logic osc_s2_reg;
    logic sup_s1_reg;
    logic sup_s2_reg;
    logic sup_prev_reg;
    logic rst_s1_reg;
    logic rst_s2_reg;
    logic alm_s1_reg;
    logic alm_s2_reg;
    logic ck_s1_reg;
    logic ck_s2_reg;
    logic [7:0] serial_reg [8];
    logic [9:0] ctrl_reg;
    logic [1:0] flags_reg;
    logic [13:0] tamper_reg;
    logic [OSCD_EV_W-1:0] irq_status_reg;
    logic [OSCD_EV_W-1:0] irq_enable_reg;
    logic [31:0] prdata_reg;
    logic supply_fall;
    logic supply_rise;
    logic in_backup;
    logic wr_access;
    logic rd_access;
    logic wr_lane0;
    logic [OSCD_EV_W-1:0] irq_events;
    logic osc_fail_irq;
    logic pin_low;

    // Pins come from other domains, so each passes two flip-flops.
    // Oscillator-running pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
        end else begin
            osc_s1_reg <= osc_running;
            osc_s2_reg <= osc_s1_reg;
        end
    end

    // Main-supply pin; a third flop keeps the last value for edge detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_s1_reg <= 1'b0;
            sup_s2_reg <= 1'b0;
            sup_prev_reg <= 1'b0;
        end else begin
            sup_s1_reg <= main_supply_ok;
            sup_s2_reg <= sup_s1_reg;
            sup_prev_reg <= sup_s2_reg;
        end
    end

    // Reset-output pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= reset_out_active;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // Alarm request pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alm_s1_reg <= 1'b0;
            alm_s2_reg <= 1'b0;
        end else begin
            alm_s1_reg <= alarm_irq;
            alm_s2_reg <= alm_s1_reg;
        end
    end

    // Clock source pin; the gated output lags it by three cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_s1_reg <= 1'b0;
            ck_s2_reg <= 1'b0;
        end else begin
            ck_s1_reg <= clk32k_in;
            ck_s2_reg <= ck_s1_reg;
        end
    end

    // R9 Both supply states
    assign in_backup = !sup_s2_reg;
    assign supply_fall = sup_prev_reg && !sup_s2_reg;
    assign supply_rise = !sup_prev_reg && sup_s2_reg;

    // Only writes with byte lane 0 enabled change the narrow fields.
    assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_access = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign wr_lane0 = wr_access && apb_req.pstrb[0];

    function automatic logic is_mapped(input logic [11:0] a);
        unique case (a)
            OSCD_ADDR_CTRL, OSCD_ADDR_FLAGS, OSCD_ADDR_TAMPER,
            OSCD_ADDR_IRQ_STATUS, OSCD_ADDR_IRQ_CLEAR, OSCD_ADDR_IRQ_ENABLE,
            OSCD_ADDR_SERIAL_LO, OSCD_ADDR_SERIAL_HI,
            OSCD_ADDR_SUPPLY: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // R11 Initial defaults
    // R14 Clock and tamper defaults
    // R12 Backup edge effects
    // R16 Undefined left alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= OSCD_CTRL_INIT;
        end else if (supply_rise) begin
            ctrl_reg[OSCD_BIT_OSC_FAIL_IRQ_EN] <= 1'b0;
            ctrl_reg[OSCD_BIT_AFE] <= 1'b0;
            ctrl_reg[OSCD_BIT_ABE] <= 1'b0;
            ctrl_reg[OSCD_BIT_SQUARE_WAVE_EN] <= 1'b0;
        end else if (supply_fall) begin
            ctrl_reg[OSCD_BIT_FT] <= 1'b0;
        end else if (wr_access && apb_req.paddr == OSCD_ADDR_CTRL) begin
            if (apb_req.pstrb[0]) begin
                ctrl_reg[7:0] <= apb_req.pwdata[7:0];
            end
            if (apb_req.pstrb[1]) begin
                ctrl_reg[9:8] <= apb_req.pwdata[9:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tamper_reg <= OSCD_TAMPER_INIT;
        end else if (supply_rise) begin
            tamper_reg[OSCD_TAMPER_IRQ_LSB +: 2] <= 2'h0;
        end else if (wr_access && apb_req.paddr == OSCD_ADDR_TAMPER) begin
            if (apb_req.pstrb[0]) begin
                tamper_reg[7:0] <= apb_req.pwdata[7:0];
            end
            if (apb_req.pstrb[1]) begin
                tamper_reg[13:8] <= apb_req.pwdata[13:8];
            end
        end
    end

    // R3 Flag starts set
    // R7 Sticky fail flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg[OSCD_BIT_OF] <= OSCD_FLAGS_INIT[OSCD_BIT_OF];
        // R2 Stop sets flag
        end else if (!osc_s2_reg) begin
            flags_reg[OSCD_BIT_OF] <= 1'b1;
        // R4 Halt sets flag
        end else if (wr_lane0 && apb_req.paddr == OSCD_ADDR_CTRL &&
                     apb_req.pwdata[OSCD_BIT_HALT]) begin
            flags_reg[OSCD_BIT_OF] <= 1'b1;
        end else if (ctrl_reg[OSCD_BIT_HALT]) begin
            flags_reg[OSCD_BIT_OF] <= 1'b1;
        // R8 Host timing trusted
        end else if (wr_lane0 && apb_req.paddr == OSCD_ADDR_FLAGS) begin
            flags_reg[OSCD_BIT_OF] <= apb_req.pwdata[OSCD_BIT_OF] &
                                      flags_reg[OSCD_BIT_OF];
        end
    end

    // R13 Tamper blocks halt-update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg[OSCD_BIT_HT] <= OSCD_FLAGS_INIT[OSCD_BIT_HT];
        end else if (supply_fall) begin
            flags_reg[OSCD_BIT_HT] <=
                ~|tamper_reg[OSCD_TAMPER_EN_LSB +: 2];
        end else if (wr_lane0 && apb_req.paddr == OSCD_ADDR_FLAGS) begin
            flags_reg[OSCD_BIT_HT] <= apb_req.pwdata[OSCD_BIT_HT];
        end
    end

    // Sticky events; a new event in the clearing cycle survives the clear.
    assign irq_events = {supply_rise, supply_fall,
                         !osc_s2_reg || ctrl_reg[OSCD_BIT_HALT]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= '0;
        end else if (wr_lane0 && apb_req.paddr == OSCD_ADDR_IRQ_CLEAR) begin
            irq_status_reg <= (irq_status_reg &
                               ~apb_req.pwdata[OSCD_EV_W-1:0]) | irq_events;
        end else begin
            irq_status_reg <= irq_status_reg | irq_events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_reg <= '0;
        end else if (wr_lane0 && apb_req.paddr == OSCD_ADDR_IRQ_ENABLE) begin
            irq_enable_reg <= apb_req.pwdata[OSCD_EV_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_enable_reg);
        end
    end

    // R5 Flag drives pin
    // R6 Clear conditions
    assign osc_fail_irq = flags_reg[OSCD_BIT_OF] &&
                          ctrl_reg[OSCD_BIT_OSC_FAIL_IRQ_EN] && !rst_s2_reg;
    // With no interrupt source armed the pin follows the output level bit.
    always_comb begin
        if (ctrl_reg[OSCD_BIT_OSC_FAIL_IRQ_EN] || ctrl_reg[OSCD_BIT_AFE]) begin
            pin_low = osc_fail_irq || (alm_s2_reg && ctrl_reg[OSCD_BIT_AFE]);
        end else begin
            pin_low = !ctrl_reg[OSCD_BIT_OUT];
        end
    end

    // R10 Backup gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_out_n_oe <= 1'b0;
        end else begin
            irq_out_n_oe <= pin_low &&
                            (!in_backup || ctrl_reg[OSCD_BIT_ABE]);
        end
    end
    // Open drain: the pin is only ever pulled low.
    assign irq_out_n_o = 1'b0;

    // R15 Clock only on main
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk32k_out <= 1'b0;
        end else begin
            clk32k_out <= ck_s2_reg && ctrl_reg[OSCD_BIT_CLK32K_OUT_EN] && !in_backup;
        end
    end

    // R1 Read-only serial
    // No write path reaches these bytes, so software can never alter them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                serial_reg[i] <= OSCD_SERIAL_DEFAULT[8*i +: 8];
            end
        end
    end

    // Read decode; the clear register is write-only and reads as zero.
    function automatic logic [31:0] read_word(input logic [11:0] a);
        unique case (a)
            OSCD_ADDR_CTRL: read_word = {22'h0, ctrl_reg};
            OSCD_ADDR_FLAGS: read_word = {30'h0, flags_reg};
            OSCD_ADDR_TAMPER: read_word = {18'h0, tamper_reg};
            OSCD_ADDR_IRQ_STATUS: read_word = {29'h0, irq_status_reg};
            OSCD_ADDR_IRQ_ENABLE: read_word = {29'h0, irq_enable_reg};
            OSCD_ADDR_SERIAL_LO: read_word = {serial_reg[3], serial_reg[2],
                                              serial_reg[1], serial_reg[0]};
            OSCD_ADDR_SERIAL_HI: read_word = {serial_reg[7], serial_reg[6],
                                              serial_reg[5], serial_reg[4]};
            OSCD_ADDR_SUPPLY: read_word = {30'h0, sup_s2_reg, osc_s2_reg};
            default: read_word = 32'h0;
        endcase
    endfunction : read_word

    // Read data is taken in the setup cycle and stands for the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (rd_access) begin
            prdata_reg <= read_word(apb_req.paddr);
        end
    end

    // Zero-wait slave: every access completes in its first access cycle.
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable &&
                             !is_mapped(apb_req.paddr);
    assign apb_rsp.prdata = prdata_reg;
endmodule : oscd_top

//--- shared/oscd_pkg.sv
// Package with register map, field layout and defaults of the oscillator-stop block.
package oscd_pkg;
    localparam logic [11:0] OSCD_ADDR_CTRL = 12'h000;
    localparam logic [11:0] OSCD_ADDR_FLAGS = 12'h004;
    localparam logic [11:0] OSCD_ADDR_TAMPER = 12'h008;
    localparam logic [11:0] OSCD_ADDR_IRQ_STATUS = 12'h00c;
    localparam logic [11:0] OSCD_ADDR_IRQ_CLEAR = 12'h010;
    localparam logic [11:0] OSCD_ADDR_IRQ_ENABLE = 12'h014;
    localparam logic [11:0] OSCD_ADDR_SERIAL_LO = 12'h018;
    localparam logic [11:0] OSCD_ADDR_SERIAL_HI = 12'h01c;
    localparam logic [11:0] OSCD_ADDR_SUPPLY = 12'h020;
    // Control register field positions.
    localparam int OSCD_BIT_TR = 0;
    localparam int OSCD_BIT_HALT = 1;
    localparam int OSCD_BIT_OSC_FAIL_IRQ_EN = 2;
    localparam int OSCD_BIT_OUT = 3;
    localparam int OSCD_BIT_FT = 4;
    localparam int OSCD_BIT_AFE = 5;
    localparam int OSCD_BIT_ABE = 6;
    localparam int OSCD_BIT_SQUARE_WAVE_EN = 7;
    localparam int OSCD_BIT_CLK32K_OUT_EN = 8;
    localparam int OSCD_BIT_THS = 9;
    // Flags register field positions.
    localparam int OSCD_BIT_OF = 0;
    localparam int OSCD_BIT_HT = 1;
    // Tamper register: 7 fields of 2 bits, tamper enables at bits 1:0.
    localparam int OSCD_TAMPER_W = 14;
    localparam int OSCD_TAMPER_EN_LSB = 0;
    localparam int OSCD_TAMPER_IRQ_LSB = 12;
    // Interrupt status event positions.
    localparam int OSCD_EV_OSC_FAIL = 0;
    localparam int OSCD_EV_SUPPLY_FALL = 1;
    localparam int OSCD_EV_SUPPLY_RISE = 2;
    localparam int OSCD_EV_W = 3;
    // Initial power-up defaults.
    localparam logic [9:0] OSCD_CTRL_INIT = 10'h108;
    localparam logic [1:0] OSCD_FLAGS_INIT = 2'h3;
    localparam logic [13:0] OSCD_TAMPER_INIT = 14'h0000;
    // Serial number, arbitrary neutral value standing for a factory number.
    localparam logic [63:0] OSCD_SERIAL_DEFAULT = 64'h0123_4567_89ab_cd00;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } oscd_apb_req_type;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } oscd_apb_rsp_type;
endpackage : oscd_pkg

//--- testbench/osc_stop_detect_and_defaults_bench.sv
// Bench for the oscillator-stop block with host model and checker.
`timescale 1ns/1ps
bind oscd_top oscd_checker i_chk (.pclk, .presetn, .apb_req, .apb_rsp,
    .osc_running, .main_supply_ok, .reset_out_active, .irq_out_n_oe,
    .clk32k_out, .irq);
module osc_stop_detect_and_defaults_bench;
    import oscd_pkg::*;
    logic pclk, presetn, osc_running, main_supply_ok, reset_out_active;
    logic alarm_irq, clk32k_in, irq_out_n_o, irq_out_n_oe, clk32k_out;
    logic irq, rd_done, ck_prev;
    logic [31:0] rd_data;
    logic [63:0] nt;
    logic [63:0] notes[$];
    oscd_apb_req_type apb_req;
    oscd_apb_rsp_type apb_rsp;
    int mismatches = 0;
    int n_compared = 0;
    int seed = 67;
    oscd_top i_dut (.pclk, .presetn, .apb_req, .apb_rsp, .osc_running,
        .main_supply_ok, .reset_out_active, .alarm_irq, .clk32k_in,
        .irq_out_n_o, .irq_out_n_oe, .clk32k_out, .irq);
    oscd_host_model i_host (.pclk, .apb_req, .apb_rsp, .rd_done, .rd_data);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'h1, a, d);
    endtask : wr
    // A note holds the mask above the expected value.
    task automatic rd(input logic [11:0] a, input logic [31:0] m,
        input logic [31:0] e);
        notes.push_back({m, e});
        i_host.xfer(1'h0, a, 32'h0);
    endtask : rd
    task automatic pins(input int n, input logic e);
        repeat (n) @(posedge pclk);
        #1 check({31'h0, irq_out_n_oe}, {31'h0, e});
        check({31'h0, irq_out_n_o}, 32'h0);
    endtask : pins
    always @(posedge pclk) begin
        clk32k_in <= ~clk32k_in;
        if (rd_done === 1'h1) begin
            nt = notes.pop_front();
            check(rd_data & nt[63:32], nt[31:0]);
        end
    end
    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
    initial begin
        presetn = 1'h0;
        osc_running = 1'h1;
        main_supply_ok = 1'h1;
        reset_out_active = 1'h0;
        alarm_irq = 1'h0;
        clk32k_in = 1'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        repeat (8) @(posedge pclk);
        rd(OSCD_ADDR_CTRL, 32'h3ff, 32'h108);
        rd(OSCD_ADDR_FLAGS, 32'h3, 32'h3);
        rd(OSCD_ADDR_TAMPER, 32'h3fff, 32'h0);
        wr(OSCD_ADDR_SERIAL_LO, $random(seed));
        wr(OSCD_ADDR_SERIAL_HI, $random(seed));
        rd(OSCD_ADDR_SERIAL_LO, '1, OSCD_SERIAL_DEFAULT[31:0]);
        rd(OSCD_ADDR_SERIAL_HI, '1, OSCD_SERIAL_DEFAULT[63:32]);
        rd(12'h024, '1, 32'h0);
        // the host lets the oscillator run before clearing the flag.
        repeat (40) @(posedge pclk);
        rd(OSCD_ADDR_FLAGS, 32'h1, 32'h1);
        wr(OSCD_ADDR_FLAGS, 32'h0);
        rd(OSCD_ADDR_FLAGS, 32'h1, 32'h0);
        wr(OSCD_ADDR_CTRL, 32'h10e);
        pins(4, 1'h1);
        rd(OSCD_ADDR_FLAGS, 32'h1, 32'h1);
        pins(1, 1'h1);
        wr(OSCD_ADDR_CTRL, 32'h108);
        pins(4, 1'h0);
        wr(OSCD_ADDR_CTRL, 32'h10c);
        pins(4, 1'h1);
        wr(OSCD_ADDR_FLAGS, 32'h0);
        pins(4, 1'h0);
        osc_running <= 1'h0;
        pins(10, 1'h1);
        rd(OSCD_ADDR_FLAGS, 32'h1, 32'h1);
        osc_running <= 1'h1;
        wr(OSCD_ADDR_IRQ_ENABLE, 32'h1);
        pins(2, 1'h1);
        check({31'h0, irq}, 32'h1);
        wr(OSCD_ADDR_IRQ_ENABLE, 32'h0);
        pins(2, 1'h1);
        check({31'h0, irq}, 32'h0);
        wr(OSCD_ADDR_IRQ_CLEAR, 32'h7);
        rd(OSCD_ADDR_IRQ_STATUS, 32'h1, 32'h0);
        wr(OSCD_ADDR_CTRL, 32'h11c);
        main_supply_ok <= 1'h0;
        pins(6, 1'h0);
        rd(OSCD_ADDR_CTRL, 32'h3ff, 32'h10c);
        main_supply_ok <= 1'h1;
        repeat (6) @(posedge pclk);
        rd(OSCD_ADDR_CTRL, 32'h3ff, 32'h108);
        wr(OSCD_ADDR_FLAGS, 32'h0);
        wr(OSCD_ADDR_CTRL, 32'h14c);
        main_supply_ok <= 1'h0;
        repeat (6) @(posedge pclk);
        osc_running <= 1'h0;
        repeat (10) @(posedge pclk);
        osc_running <= 1'h1;
        pins(4, 1'h1);
        main_supply_ok <= 1'h1;
        repeat (6) @(posedge pclk);
        rd(OSCD_ADDR_FLAGS, 32'h3, 32'h3);
        wr(OSCD_ADDR_CTRL, 32'h10c);
        pins(4, 1'h1);
        reset_out_active <= 1'h1;
        pins(6, 1'h0);
        ck_prev = clk32k_out;
        @(posedge pclk);
        #1 check({31'h0, clk32k_out}, {31'h0, ~ck_prev});
        wr(OSCD_ADDR_TAMPER, 32'h1);
        wr(OSCD_ADDR_FLAGS, 32'h0);
        main_supply_ok <= 1'h0;
        repeat (6) @(posedge pclk);
        #1 check({31'h0, clk32k_out}, 32'h0);
        rd(OSCD_ADDR_FLAGS, 32'h2, 32'h0);
        main_supply_ok <= 1'h1;
        repeat (6) @(posedge pclk);
        conclude();
    end
endmodule : osc_stop_detect_and_defaults_bench

//--- testbench/oscd_checker.sv
// Port checker for the oscillator-stop block.
`timescale 1ns/1ps
module oscd_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire oscd_pkg::oscd_apb_req_type apb_req,
    input wire oscd_pkg::oscd_apb_rsp_type apb_rsp,
    input wire logic osc_running,
    input wire logic main_supply_ok,
    input wire logic reset_out_active,
    input wire logic irq_out_n_oe,
    input wire logic clk32k_out,
    input wire logic irq
);
    import oscd_pkg::*;
    logic acc, rd, ctrl_wr, abe_reg;
    assign acc = apb_req.psel && apb_req.penable;
    assign rd = acc && !apb_req.pwrite;
    assign ctrl_wr = acc && apb_req.pwrite && apb_req.pstrb[0] &&
        apb_req.paddr == OSCD_ADDR_CTRL;
    // The shadow ignores the clear on supply rise; that only weakens a check.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abe_reg <= 1'h0;
        end else if (ctrl_wr) begin
            abe_reg <= apb_req.pwdata[OSCD_BIT_ABE];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence osc_down;
        !osc_running [*8];
    endsequence
    sequence quiet_main;
        (main_supply_ok && !reset_out_active) [*4];
    endsequence
    a_ready_always: assert property (acc |-> apb_rsp.pready)
        else $error("pready low in access phase");
    a_slverr_unmapped: assert property (
        acc && apb_req.paddr > OSCD_ADDR_SUPPLY |-> apb_rsp.pslverr)
        else $error("unmapped access without pslverr");
    a_serial_fixed: assert property (
        rd && apb_req.paddr == OSCD_ADDR_SERIAL_LO
        |-> apb_rsp.prdata == OSCD_SERIAL_DEFAULT[31:0])
        else $error("serial low word changed");
    a_stop_sets_flag: assert property (
        osc_down ##0 (rd && apb_req.paddr == OSCD_ADDR_FLAGS)
        |-> apb_rsp.prdata[OSCD_BIT_OF]) else $error("stop not flagged");
    a_halt_drives_pin: assert property (
        quiet_main ##0 (ctrl_wr && apb_req.pwdata[OSCD_BIT_HALT] &&
        apb_req.pwdata[OSCD_BIT_OSC_FAIL_IRQ_EN]) |-> ##2 irq_out_n_oe)
        else $error("halt with enable did not drive pin");
    a_pin_released: assert property (
        ctrl_wr && !apb_req.pwdata[OSCD_BIT_OSC_FAIL_IRQ_EN] &&
        !apb_req.pwdata[OSCD_BIT_AFE] && apb_req.pwdata[OSCD_BIT_OUT]
        |-> ##2 !irq_out_n_oe) else $error("pin held after enable clear");
    a_backup_quiet: assert property (
        (!main_supply_ok && !abe_reg) [*5] |-> !irq_out_n_oe)
        else $error("pin driven in backup without enable");
    a_clk_backup: assert property (
        !main_supply_ok [*5] |-> !clk32k_out)
        else $error("clock output in backup");
    a_irq_masked: assert property (acc && apb_req.pwrite &&
        apb_req.paddr == OSCD_ADDR_IRQ_ENABLE &&
        apb_req.pwdata[2:0] == 3'h0 |-> ##2 !irq)
        else $error("irq high with enables clear");
endmodule : oscd_checker

//--- testbench/oscd_host_model.sv
// APB host model that issues transfers and reports read data.
`timescale 1ns/1ps
module oscd_host_model (
    input wire logic pclk,
    output oscd_pkg::oscd_apb_req_type apb_req,
    input wire oscd_pkg::oscd_apb_rsp_type apb_rsp,
    output logic rd_done,
    output logic [31:0] rd_data
);
    import oscd_pkg::*;
    initial begin
        apb_req = '0;
        rd_done = 1'h0;
        rd_data = 32'h0;
    end
    // The request stands unchanged until pready is seen at an edge.
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        apb_req <= '{1'h1, 1'h0, w, a, d, 4'hf};
        @(posedge pclk);
        apb_req.penable <= 1'h1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'h1);
        rd_data <= apb_rsp.prdata;
        rd_done <= !w;
        apb_req <= '0;
        @(posedge pclk);
        rd_done <= 1'h0;
    endtask : xfer
endmodule : oscd_host_model
